// file: design/apc_top.sv
/*
 Audio port control: AXI4-Lite register file steering PLL choice and tuning,
 master clock divider, serial port start/stop and DMA requests, codec
 configuration link and codec volume, gain, boost and mute settings.
 Assumes the codec link, DMA buffers and PLLs run on aclk.
*/
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - Sample rates 8/16/32/48/96k select PLL one; 44.1/88.2k select PLL two.
// - Divider makes master clock enable at 256 or 128 times sample rate.
// - Each PLL enabled alone; accepts ppm tune faster, slower or auto.
// - Transmit path has its own start and stop control.
// - Receive path has its own start and stop control.
// - Separate DMA request enables; cleared enable means no requests.
// - Only mono and stereo channel settings exist.
// - Word length is writable and reads back as programmed.
// - Codec link has an enable and carries register writes and reads.
// - A gate switches the codec register bank clock.
// - DAC volume codes are 8 bits; 0xAF is 0 dB.
// - Volume reads back right code high byte, left code low byte.
// - Left and right record channels mute independently.
// - Left and right playback channels mute independently.
// - One sample rate setting drives both ADC and DAC.
// - ADC left and right gains are separately programmable.
// - Boost set per side for analog and digital microphones.
// - Formats I2S, left-justified, PCM A, B, A-N, B-N.
// - Auto mode PLL outputs 196.608 MHz and 180.6336 MHz.
module apc_top
    import apc_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             pll_sel,
    output logic             pll1_en,
    output logic             pll2_en,
    output logic [7:0]       pll1_tune_ppm,
    output logic [1:0]       pll1_tune_act,
    output logic [7:0]       pll2_tune_ppm,
    output logic [1:0]       pll2_tune_act,
    output logic             mclk_ratio_128,
    output logic             mclk_en,
    output logic             sp_tx_run,
    output logic             sp_rx_run,
    output logic             sp_stereo,
    output logic [1:0]       sp_word_len,
    output logic [2:0]       sp_format,
    input  wire logic        tx_buf_ready,
    input  wire logic        rx_buf_valid,
    input  wire logic        tx_xfer_done,
    input  wire logic        rx_xfer_done,
    output logic             tx_dma_req,
    output logic             rx_dma_req,
    output logic             si_enable,
    output logic             regbank_clk_en,
    output logic             si_req,
    output logic             si_we,
    output logic [7:0]       si_addr,
    output logic [15:0]      si_wdata,
    input  wire logic        si_ack,
    input  wire logic [15:0] si_rdata,
    output logic [7:0]       dac_vol_l,
    output logic [7:0]       dac_vol_r,
    output logic [7:0]       adc_gain_l,
    output logic [7:0]       adc_gain_r,
    output logic [1:0]       amic_bst_l,
    output logic [1:0]       amic_bst_r,
    output logic [1:0]       dmic_bst_l,
    output logic [1:0]       dmic_bst_r,
    output logic             adc_mute_l,
    output logic             adc_mute_r,
    output logic             dac_mute_l,
    output logic             dac_mute_r,
    output logic [3:0]       sample_rate
);
    // Address to register index; NREG means unmapped
    function automatic int unsigned reg_idx(input logic [7:0] a);
        int unsigned i;
        i = NREG;
        if (a[1:0] == 2'h0 && a <= ADDR_SRATE) begin
            i = int'(a[7:2]);
        end
        return i;
    endfunction

    function automatic logic [31:0] reg_mask(input int unsigned i);
        logic [31:0] m;
        case (i)
            0: m = MASK_CLK;
            1, 2: m = MASK_TUNE;
            3: m = MASK_SP;
            4: m = MASK_SI;
            6, 7: m = MASK_16;
            8: m = MASK_BOOST;
            9: m = MASK_MUTE;
            10: m = MASK_SRATE;
            default: m = '0;
        endcase
        return m;
    endfunction

    logic [31:0] regs_q [NREG];
    logic [31:0] regs_d [NREG];
    logic        aw_got_q, aw_got_d, w_got_q, w_got_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [7:0]  awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic [3:0]  wstrb_q, wstrb_d;
    logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
    logic        wr_fire;
    logic [31:0] wr_val;
    int unsigned wi;
    apc_si_e     si_q, si_d;
    logic [15:0] si_rd_q, si_rd_d;
    logic [8:0]  div_cnt_q, div_cnt_d, div_lim;
    logic        cmd_go;

    // Bus handshakes; a write commits once address and data are both held
    assign s_axi_awready = !aw_got_q && !bvalid_q;
    assign s_axi_wready  = !w_got_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;
    assign wr_fire = aw_got_q && w_got_q;
    assign wi      = reg_idx(awaddr_q);
    assign cmd_go  = wr_fire && wi == int'(ADDR_SICMD[7:2]) && regs_q[4][SI_EN] && si_q == SI_IDLE;

    // Bus channel state and read data
    always_comb begin
        aw_got_d = aw_got_q;
        w_got_d  = w_got_q;
        awaddr_d = awaddr_q;
        wdata_d  = wdata_q;
        wstrb_d  = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d  = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d  = rresp_q;
        rdata_d  = rdata_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_got_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_got_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (wr_fire) begin
            aw_got_d = 1'b0;
            w_got_d  = 1'b0;
            bvalid_d = 1'b1;
            bresp_d  = (wi < NREG) ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d  = (reg_idx(s_axi_araddr) < NREG) ? RESP_OKAY : RESP_SLVERR;
            rdata_d  = '0;
            case (reg_idx(s_axi_araddr))
                4: rdata_d = regs_q[4] | ({31'h0, si_q == SI_WAIT} << SI_BUSY);
                5: rdata_d = {16'h0, si_rd_q};
                NREG: rdata_d = '0;
                default: rdata_d = regs_q[reg_idx(s_axi_araddr)];
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    // Register updates with byte enables; illegal codes keep the old value
    always_comb begin
        for (int i = 0; i < NREG; i++) begin
            regs_d[i] = regs_q[i];
        end
        for (int b = 0; b < 4; b++) begin
            wr_val[b*8 +: 8] = wstrb_q[b] ? wdata_q[b*8 +: 8] : regs_q[wi % NREG][b*8 +: 8];
        end
        if (wr_fire && wi < NREG) begin
            regs_d[wi] = wr_val & reg_mask(wi);
            if (wi == int'(ADDR_SP[7:2]) && wr_val[SP_FMT_LO +: 3] > FMT_PCMBN) begin
                regs_d[wi][SP_FMT_LO +: 3] = regs_q[wi][SP_FMT_LO +: 3];
            end
            if (wi == int'(ADDR_SRATE[7:2]) && wr_val[3:0] > SR_88K2) begin
                regs_d[wi] = regs_q[wi];
            end
        end
        // Finished transfer stops a path without DMA, unless restarted now
        if (tx_xfer_done && !regs_q[3][SP_TX_DMA]
            && !(wr_fire && wi == int'(ADDR_SP[7:2]) && wr_val[SP_TX_RUN])) begin
            regs_d[3][SP_TX_RUN] = 1'b0;
        end
        if (rx_xfer_done && !regs_q[3][SP_RX_DMA]
            && !(wr_fire && wi == int'(ADDR_SP[7:2]) && wr_val[SP_RX_RUN])) begin
            regs_d[3][SP_RX_RUN] = 1'b0;
        end
    end

    // Codec link: one transaction outstanding, held until acknowledged
    always_comb begin
        si_d    = si_q;
        si_rd_d = si_rd_q;
        case (si_q)
            SI_IDLE: if (cmd_go) begin
                si_d = SI_WAIT;
            end
            SI_WAIT: if (si_ack) begin
                si_d = SI_IDLE;
                if (!si_we) begin
                    si_rd_d = si_rdata;
                end
            end
            default: si_d = SI_IDLE;
        endcase
    end

    // Master clock enable divider; 128 fs runs at twice the count of 256 fs
    assign div_lim = regs_q[0][CLK_R128] ? {regs_q[0][CLK_DIV_LO +: 8], 1'b0}
                                         : {1'b0, regs_q[0][CLK_DIV_LO +: 8]};
    always_comb begin
        div_cnt_d = div_cnt_q + 9'h001;
        if (div_lim == 9'h000 || div_cnt_q >= div_lim - 9'h001) begin
            div_cnt_d = 9'h000;
        end
    end
    assign mclk_en = div_lim != 9'h000 && div_cnt_q >= div_lim - 9'h001;

    // All state registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NREG; i++) begin
                regs_q[i] <= (i == 0) ? RST_CLK : (i == 6) ? RST_VOL : '0;
            end
            {aw_got_q, w_got_q, bvalid_q, rvalid_q} <= '0;
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
            bresp_q   <= RESP_OKAY;
            rresp_q   <= RESP_OKAY;
            rdata_q   <= '0;
            si_q      <= SI_IDLE;
            si_rd_q   <= '0;
            si_we     <= 1'b0;
            si_addr   <= '0;
            si_wdata  <= '0;
            div_cnt_q <= '0;
        end else begin
            regs_q    <= regs_d;
            {aw_got_q, w_got_q, bvalid_q, rvalid_q} <= {aw_got_d, w_got_d, bvalid_d, rvalid_d};
            awaddr_q  <= awaddr_d;
            wdata_q   <= wdata_d;
            wstrb_q   <= wstrb_d;
            bresp_q   <= bresp_d;
            rresp_q   <= rresp_d;
            rdata_q   <= rdata_d;
            si_q      <= si_d;
            si_rd_q   <= si_rd_d;
            div_cnt_q <= div_cnt_d;
            if (cmd_go) begin
                si_we    <= wr_val[CMD_WRITE];
                si_addr  <= wr_val[7:0];
                si_wdata <= wr_val[CMD_DATA_LO +: 16];
            end
        end
    end

    // Register fields onto the control outputs
    assign sample_rate = regs_q[10][3:0];
    assign pll_sel = sample_rate == SR_44K1 || sample_rate == SR_88K2;
    assign pll1_en = regs_q[0][CLK_PLL1_EN];
    assign pll2_en = regs_q[0][CLK_PLL2_EN];
    assign pll1_tune_ppm = regs_q[1][7:0];
    assign pll1_tune_act = regs_q[1][TUNE_ACT_LO +: 2];
    assign pll2_tune_ppm = regs_q[2][7:0];
    assign pll2_tune_act = regs_q[2][TUNE_ACT_LO +: 2];
    assign mclk_ratio_128 = regs_q[0][CLK_R128];
    assign sp_tx_run   = regs_q[3][SP_TX_RUN];
    assign sp_rx_run   = regs_q[3][SP_RX_RUN];
    assign sp_stereo   = regs_q[3][SP_STEREO];
    assign sp_word_len = regs_q[3][SP_WLEN_LO +: 2];
    assign sp_format   = regs_q[3][SP_FMT_LO +: 3];
    assign tx_dma_req  = sp_tx_run && regs_q[3][SP_TX_DMA] && tx_buf_ready;
    assign rx_dma_req  = sp_rx_run && regs_q[3][SP_RX_DMA] && rx_buf_valid;
    assign si_enable      = regs_q[4][SI_EN];
    assign regbank_clk_en = regs_q[4][SI_BANK_CLK];
    assign si_req = si_q == SI_WAIT;
    assign {dac_vol_r, dac_vol_l}   = regs_q[6][15:0];
    assign {adc_gain_r, adc_gain_l} = regs_q[7][15:0];
    assign {dmic_bst_r, dmic_bst_l, amic_bst_r, amic_bst_l} = regs_q[8][7:0];
    assign {dac_mute_r, dac_mute_l, adc_mute_r, adc_mute_l} = regs_q[9][3:0];

    // Checks
    sequence s_cmd_issued;
        cmd_go ##1 si_req;
    endsequence
    a_si_cmd_start: assert property (@(posedge aclk) disable iff (!aresetn)
        cmd_go |=> si_req) else $error("link request missing");
    a_si_req_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        s_cmd_issued ##0 !si_ack |=> si_req && $stable(si_addr))
        else $error("link request dropped");
    a_si_no_overlap: assert property (@(posedge aclk) disable iff (!aresetn)
        si_req && !si_ack |=> $stable(si_wdata) && $stable(si_we))
        else $error("link command changed while busy");
    a_tx_dma_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        tx_dma_req |-> sp_tx_run && regs_q[3][SP_TX_DMA] && tx_buf_ready)
        else $error("tx dma request ungated");
    a_rx_dma_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        !regs_q[3][SP_RX_DMA] || !sp_rx_run |-> !rx_dma_req)
        else $error("rx dma request while disabled");
    a_pll_select: assert property (@(posedge aclk) disable iff (!aresetn)
        sample_rate <= SR_96K |-> !pll_sel) else $error("wrong pll chosen");
    a_mclk_spacing: assert property (@(posedge aclk) disable iff (!aresetn)
        mclk_en && div_lim > 9'h001 && $stable(div_lim) |=> !mclk_en)
        else $error("master clock enable too close");
    a_tx_stop_done: assert property (@(posedge aclk) disable iff (!aresetn)
        tx_xfer_done && !regs_q[3][SP_TX_DMA] && !wr_fire |=> !sp_tx_run)
        else $error("tx path not stopped");
    a_fmt_legal: assert property (@(posedge aclk) disable iff (!aresetn)
        sp_format <= FMT_PCMBN) else $error("illegal format held");
    a_vol_readback: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_VOL
        |=> s_axi_rdata[15:0] == {$past(dac_vol_r), $past(dac_vol_l)})
        else $error("volume readback wrong");
    a_wlen_readback: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_SP
        |=> s_axi_rdata[SP_WLEN_LO +: 2] == $past(sp_word_len))
        else $error("word length readback wrong");
endmodule

// file: design/apc_pkg.sv
/*
 Constants shared by the audio port control block: register map, field
 positions, reset values, encodings and clock figures.
 Assumes a 32-bit AXI4-Lite register bus with one word per register.
*/
package apc_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_CLK   = 8'h00;
    localparam logic [7:0] ADDR_TUNE1 = 8'h04;
    localparam logic [7:0] ADDR_TUNE2 = 8'h08;
    localparam logic [7:0] ADDR_SP    = 8'h0C;
    localparam logic [7:0] ADDR_SI    = 8'h10;
    localparam logic [7:0] ADDR_SICMD = 8'h14;
    localparam logic [7:0] ADDR_VOL   = 8'h18;
    localparam logic [7:0] ADDR_ADCG  = 8'h1C;
    localparam logic [7:0] ADDR_BOOST = 8'h20;
    localparam logic [7:0] ADDR_MUTE  = 8'h24;
    localparam logic [7:0] ADDR_SRATE = 8'h28;
    localparam int         NREG       = 11;

    // Writable bits of each stored register
    localparam logic [31:0] MASK_CLK   = 32'h0000_FF07;
    localparam logic [31:0] MASK_TUNE  = 32'h0000_03FF;
    localparam logic [31:0] MASK_SP    = 32'h0000_077F;
    localparam logic [31:0] MASK_SI    = 32'h0000_0003;
    localparam logic [31:0] MASK_16    = 32'h0000_FFFF;
    localparam logic [31:0] MASK_BOOST = 32'h0000_00FF;
    localparam logic [31:0] MASK_MUTE  = 32'h0000_000F;
    localparam logic [31:0] MASK_SRATE = 32'h0000_000F;

    // Reset values: divider 16, both DAC volumes at 0 dB
    localparam logic [31:0] RST_CLK = 32'h0000_1000;
    localparam logic [31:0] RST_VOL = 32'h0000_AFAF;

    // Field positions
    localparam int CLK_PLL1_EN = 0;
    localparam int CLK_PLL2_EN = 1;
    localparam int CLK_R128    = 2;
    localparam int CLK_DIV_LO  = 8;
    localparam int TUNE_ACT_LO = 8;
    localparam int SP_TX_RUN   = 0;
    localparam int SP_RX_RUN   = 1;
    localparam int SP_TX_DMA   = 2;
    localparam int SP_RX_DMA   = 3;
    localparam int SP_STEREO   = 4;
    localparam int SP_WLEN_LO  = 5;
    localparam int SP_FMT_LO   = 8;
    localparam int SI_EN       = 0;
    localparam int SI_BANK_CLK = 1;
    localparam int SI_BUSY     = 8;
    localparam int CMD_DATA_LO = 8;
    localparam int CMD_WRITE   = 31;

    // Data formats; codes above the last are refused
    localparam logic [2:0] FMT_I2S = 3'h0;
    localparam logic [2:0] FMT_LJ  = 3'h1;
    localparam logic [2:0] FMT_PCMA = 3'h2;
    localparam logic [2:0] FMT_PCMB = 3'h3;
    localparam logic [2:0] FMT_PCMAN = 3'h4;
    localparam logic [2:0] FMT_PCMBN = 3'h5;

    // Sample rate codes
    localparam logic [3:0] SR_8K   = 4'h0;
    localparam logic [3:0] SR_16K  = 4'h1;
    localparam logic [3:0] SR_32K  = 4'h2;
    localparam logic [3:0] SR_48K  = 4'h3;
    localparam logic [3:0] SR_96K  = 4'h4;
    localparam logic [3:0] SR_44K1 = 4'h5;
    localparam logic [3:0] SR_88K2 = 4'h6;

    // PLL tuning actions
    localparam logic [1:0] TUNE_AUTO   = 2'h0;
    localparam logic [1:0] TUNE_FASTER = 2'h1;
    localparam logic [1:0] TUNE_SLOWER = 2'h2;

    // Automatic-mode PLL outputs in Hz, and bus clock
    localparam longint PLL1_AUTO_HZ = 64'd196608000;
    localparam longint PLL2_AUTO_HZ = 64'd180633600;
    localparam int     ACLK_HZ      = 50_000_000;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        SI_IDLE = 2'b01,
        SI_WAIT = 2'b10
    } apc_si_e;
endpackage

// file: bench/apc_codec_model.sv
/*
 Codec register bank model answering the configuration link.
 Assumes the link runs on aclk; lat sets the reply delay in cycles.
*/
`timescale 1ns/1ps
module apc_codec_model (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  lat,
    input  wire logic        si_req,
    input  wire logic        si_we,
    input  wire logic [7:0]  si_addr,
    input  wire logic [15:0] si_wdata,
    output logic             si_ack,
    output logic [15:0]      si_rdata
);
    logic [15:0] mem [256];
    logic [7:0]  cnt = 8'h00;
    initial si_ack = 1'b0;
    initial si_rdata = 16'h5A5A;
    // Reply lat+1 cycles after a request is seen; data line churns outside replies
    always @(posedge aclk) begin
        si_ack   <= 1'b0;
        si_rdata <= ~si_rdata;
        if (!aresetn) begin
            cnt <= 8'h00;
        end else if (si_req && !si_ack) begin
            cnt <= cnt + 8'h01;
            if (cnt == lat) begin
                cnt    <= 8'h00;
                si_ack <= 1'b1;
                if (si_we) begin
                    mem[si_addr] <= si_wdata;
                end else begin
                    si_rdata <= mem[si_addr];
                end
            end
        end
    end
endmodule

// file: bench/test_audio_port_control.sv
/*
 Self-checking bench for the audio port control block.
 Assumes an AXI4-Lite master here and the codec model on the link.
*/
`timescale 1ns/1ps
module test_audio_port_control
    import apc_pkg::*;
;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, tx_buf_ready = 0, rx_buf_valid = 0;
    logic tx_xfer_done = 0, rx_xfer_done = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, pll_sel, pll1_en, pll2_en, mclk_ratio_128, mclk_en;
    logic sp_tx_run, sp_rx_run, sp_stereo, tx_dma_req, rx_dma_req, si_enable;
    logic regbank_clk_en, si_req, si_we, si_ack, adc_mute_l, adc_mute_r, dac_mute_l, dac_mute_r;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, lat = 0, pll1_tune_ppm, pll2_tune_ppm;
    logic [7:0]  si_addr, dac_vol_l, dac_vol_r, adc_gain_l, adc_gain_r;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hF, sample_rate;
    logic [1:0]  s_axi_bresp, s_axi_rresp, pll1_tune_act, pll2_tune_act, sp_word_len;
    logic [1:0]  amic_bst_l, amic_bst_r, dmic_bst_l, dmic_bst_r;
    logic [2:0]  sp_format;
    logic [15:0] si_wdata, si_rdata;
    int          num_errors = 0, checked = 0, cyc = 0;

    apc_top i_apc_top (.*);
    apc_codec_model i_apc_codec_model (.*);

    always #10 aclk = ~aclk;
    // Hang guard
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask

    // AXI4-Lite write; address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er = RESP_OKAY);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask

    // AXI4-Lite read into rd
    task automatic rdr(input logic [7:0] a, input logic [1:0] er = RESP_OKAY);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        s_axi_rready <= 1'b0;
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rdr(a);
        chk("readback", e, rd);
    endtask

    // Cycles between master clock enables
    task automatic per(input int e);
        int n;
        n = 0;
        do begin
            @(posedge aclk);
        end while (mclk_en !== 1'b1);
        do begin
            @(posedge aclk);
            n++;
        end while (mclk_en !== 1'b1);
        chk("mclk period", e, n);
    endtask

    task automatic pulse_done(input logic tx);
        if (tx) tx_xfer_done <= 1'b1;
        else rx_xfer_done <= 1'b1;
        @(posedge aclk);
        tx_xfer_done <= 1'b0;
        rx_xfer_done <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic si_idle;
        do rdr(ADDR_SI);
        while (rd[SI_BUSY] !== 1'b0);
    endtask

    // Main sequence
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rc(ADDR_CLK, 32'h0000_1000);
        rc(ADDR_VOL, 32'h0000_AFAF);
        rc(ADDR_SP, 32'h0000_0000);
        wr(8'h40, 32'h0000_0001, RESP_SLVERR);
        rdr(8'h02, RESP_SLVERR);
        $display("test reset and map done");
        for (int i = 0; i < 7; i++) begin
            wr(ADDR_SRATE, i);
            chk("sample_rate", i, {28'h0, sample_rate});
            chk("pll_sel", i >= 5, {31'h0, pll_sel});
        end
        wr(ADDR_SRATE, 32'h0000_0007);
        chk("sample_rate kept", 32'h0000_0006, {28'h0, sample_rate});
        wr(ADDR_CLK, 32'h0000_0401);
        chk("clk outs", 32'h0000_0001, {29'h0, mclk_ratio_128, pll2_en, pll1_en});
        per(4);
        wr(ADDR_CLK, 32'h0000_0406);
        chk("clk outs", 32'h0000_0006, {29'h0, mclk_ratio_128, pll2_en, pll1_en});
        per(8);
        for (int a = 0; a < 3; a++) begin
            wr(ADDR_TUNE1, a * 256 + 100);
            wr(ADDR_TUNE2, (2 - a) * 256 + 7);
            chk("tune1", a * 256 + 100, {22'h0, pll1_tune_act, pll1_tune_ppm});
            chk("tune2", (2 - a) * 256 + 7, {22'h0, pll2_tune_act, pll2_tune_ppm});
        end
        $display("test clocks done");
        wr(ADDR_SP, 32'h0000_0001);
        chk("tx only", 32'h0000_0001, {30'h0, sp_rx_run, sp_tx_run});
        wr(ADDR_SP, 32'h0000_0002);
        chk("rx only", 32'h0000_0002, {30'h0, sp_rx_run, sp_tx_run});
        tx_buf_ready <= 1'b1;
        rx_buf_valid <= 1'b1;
        wr(ADDR_SP, 32'h0000_0007);
        chk("dma tx", 32'h0000_0001, {30'h0, rx_dma_req, tx_dma_req});
        wr(ADDR_SP, 32'h0000_000B);
        chk("dma rx", 32'h0000_0002, {30'h0, rx_dma_req, tx_dma_req});
        rx_buf_valid <= 1'b0;
        @(posedge aclk);
        chk("dma rx empty", 32'h0000_0000, {31'h0, rx_dma_req});
        rx_buf_valid <= 1'b1;
        wr(ADDR_SP, 32'h0000_0009);
        chk("dma rx stopped", 32'h0000_0000, {31'h0, rx_dma_req});
        for (int f = 0; f < 6; f++) begin
            wr(ADDR_SP, f * 256 + 16 + (f % 4) * 32);
            chk("format", f, {29'h0, sp_format});
            chk("stereo wlen", 4 + f % 4, {29'h0, sp_stereo, sp_word_len});
            rc(ADDR_SP, f * 256 + 16 + (f % 4) * 32);
        end
        wr(ADDR_SP, 32'h0000_0600);
        chk("format kept", 32'h0000_0005, {28'h0, sp_stereo, sp_format});
        wr(ADDR_SP, 32'h0000_0003);
        pulse_done(1'b1);
        chk("tx ends", 32'h0000_0002, {30'h0, sp_rx_run, sp_tx_run});
        wr(ADDR_SP, 32'h0000_0003);
        pulse_done(1'b0);
        chk("rx ends", 32'h0000_0001, {30'h0, sp_rx_run, sp_tx_run});
        wr(ADDR_SP, 32'h0000_0007);
        pulse_done(1'b1);
        chk("tx dma keeps run", 32'h0000_0001, {31'h0, sp_tx_run});
        $display("test serial port done");
        lat <= 8'd20;
        wr(ADDR_SI, 32'h0000_0003);
        chk("si en clk", 32'h0000_0003, {30'h0, regbank_clk_en, si_enable});
        wr(ADDR_SICMD, 32'h80BE_EF12);
        rc(ADDR_SI, 32'h0000_0103);
        chk("si req", 32'h03BE_EF12, {6'h0, si_req, si_we, si_wdata, si_addr});
        wr(ADDR_SICMD, 32'h8012_3412);
        si_idle();
        lat <= 8'd0;
        wr(ADDR_SICMD, 32'h0000_0012);
        si_idle();
        chk("si idle", 32'h0000_0003, rd);
        rdr(ADDR_SICMD);
        chk("si read", 32'h0000_BEEF, {16'h0, rd[15:0]});
        wr(ADDR_SI, 32'h0000_0000);
        wr(ADDR_SICMD, 32'h8000_0033);
        @(posedge aclk);
        chk("si off", 32'h0000_0000, {30'h0, si_req, regbank_clk_en});
        $display("test codec link done");
        wr(ADDR_VOL, 32'h0000_00AF);
        chk("dac vol", 32'h0000_00AF, {16'h0, dac_vol_r, dac_vol_l});
        rc(ADDR_VOL, 32'h0000_00AF);
        wr(ADDR_VOL, 32'h0000_5A00);
        rc(ADDR_VOL, 32'h0000_5A00);
        wr(ADDR_ADCG, 32'h0000_3C7F);
        chk("adc gain", 32'h0000_3C7F, {16'h0, adc_gain_r, adc_gain_l});
        wr(ADDR_BOOST, 32'h0000_00E4);
        chk("boost", 32'h0000_00E4,
            {24'h0, dmic_bst_r, dmic_bst_l, amic_bst_r, amic_bst_l});
        wr(ADDR_BOOST, 32'h0000_001B);
        chk("boost", 32'h0000_001B,
            {24'h0, dmic_bst_r, dmic_bst_l, amic_bst_r, amic_bst_l});
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_MUTE, 1 << i);
            chk("mute", 1 << i,
                {28'h0, dac_mute_r, dac_mute_l, adc_mute_r, adc_mute_l});
        end
        $display("test codec settings done");
        give_verdict();
    end
endmodule
